// ==== design/trig_dispatch_defs.vh ====
`ifndef TRIG_DISPATCH_DEFS_VH
`define TRIG_DISPATCH_DEFS_VH

// Register byte offsets.
`define REG_CTRL        8'h00
`define REG_STAGE       8'h04
`define REG_APPLY       8'h08
`define REG_GSEL        8'h0C
`define REG_GCFG        8'h10
`define REG_GDEF        8'h14
`define REG_CSEL        8'h18
`define REG_CMD         8'h1C
`define REG_NAME        8'h20
`define REG_STATUS      8'h24
`define REG_CINFO       8'h28
`define REG_CVAL        8'h2C

// CTRL fields.
`define CTRL_PROF_LSB   0
`define CTRL_LOCK_BIT   4

// STAGE fields.
`define STG_MASK_LSB    0
`define STG_EVT_LSB     8
`define STG_IN_LSB      10
`define STG_PROF_LSB    12

// Group configuration fields (GCFG and GDEF).
`define GC_CODE_LSB     0
`define GC_DIRECT_BIT   8
`define GC_MODEL_LSB    9
`define GC_TOL_LSB      11
`define GC_TOL_W        13

// CMD bits.
`define CMD_DEL_GROUP   0
`define CMD_DEL_COLOR   1
`define CMD_DEL_TABLE   2
`define CMD_DEL_COLORS  3

// CVAL fields: value in hundredths, coordinate index.
`define CV_VAL_LSB      0
`define CV_IDX_LSB      16

// Trigger event indexes.
`define EVT_HIGH        2'd0
`define EVT_LOW         2'd1
`define EVT_RISE        2'd2
`define EVT_FALL        2'd3

// Action bits; bits 0 to 6 run lower index first, bit 7 acts in the cycle of its request.
`define ACT_DEL_TABLE   0
`define ACT_TEACH_NEW   1
`define ACT_TEACH_ADD   2
`define ACT_TEACH_CONT  3
`define ACT_AUTOGAIN    4
`define ACT_WHITE_REF   5
`define ACT_KEY_LOCK    6
`define ACT_SWITCH_OUT  7

// Distance models.
`define MODEL_CLASSIFY  2'd0
`define MODEL_SPHERE    2'd1
`define MODEL_CYLINDER  2'd2
`define MODEL_BOX       2'd3

// Limits and reset values.
`define NAME_MAX_LEN    7'd64
`define TOL_MAX         13'd5000
`define GDEF_RESET      32'h0000_0000

// Report tick timing.
`define CLK_HZ          100000000
`define REPORT_RATE_HZ  15
`define REPORT_CYC      (`CLK_HZ / `REPORT_RATE_HZ)

`endif

// ==== design/trigger_input_action_dispatch.v ====
// Notes on behaviour
// - One or four trigger inputs per variant.
// - Each input holds four event action sets.
// - Events: level high, low, rising, falling.
// - Trigger setup per profile, switches immediately.
// - One event may start several actions.
// - Eight actions: outputs, teach, delete, autogain, lock.
// - Staged trigger setup takes effect on apply.
// - Group delete removes group and its colors.
// - Color delete removes one color only.
// - Table delete empties all colors and groups.
// - Keypad may delete groups, table; trigger the table only.
// - Group pattern: binary 1..255 or direct one-of-eight.
// - Group model: classify, sphere, cylinder, box.
// - Coordinates held in hundredths.
// - Group names: 64 chars, restricted character set.
// - Outputs update only while trigger condition present.
// - Report tick stays at fixed 15 Hz.
// - Level trigger repeats action while level holds.
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
`include "trig_dispatch_defs.vh"

module trigger_input_action_dispatch #(
   parameter NUM_INPUTS    = 4,
   parameter NUM_PROFILES  = 4,
   parameter NUM_GROUPS    = 8,
   parameter NUM_COLORS    = 16,
   parameter REPORT_PERIOD = `REPORT_CYC
) (
   input  wire        ref_clk_i,
   input  wire        rst_b_i,
   input  wire [7:0]  addr_i,
   input  wire [31:0] wdata_i,
   input  wire        wr_i,
   input  wire        rd_i,
   output reg  [31:0] rdata_o,
   input  wire [3:0]  trig_i,
   input  wire        match_valid_i,
   input  wire [2:0]  match_grp_i,
   input  wire [15:0] meas_c0_i,
   input  wire [15:0] meas_c1_i,
   input  wire [15:0] meas_c2_i,
   input  wire        key_del_group_i,
   input  wire        key_del_table_i,
   output reg  [7:0]  out_o,
   output reg         autogain_req_o,
   output reg         white_ref_req_o,
   output reg         key_lock_o,
   output reg         report_tick_o
);

   localparam NSLOT = NUM_PROFILES * 16;

   // Returns {found, index} of the lowest clear bit of a 16-bit vector.
   function [4:0] first_zero;
      input [15:0] v;
      integer k;
      begin
         first_zero = 5'd0;
         for (k = 15; k >= 0; k = k - 1) begin
            if (!v[k]) begin
               first_zero = {1'b1, k[3:0]};
            end
         end
      end
   endfunction

   function name_char_ok;
      input [7:0] c;
      begin
         name_char_ok = (c >= 8'h61 && c <= 8'h7A) || (c >= 8'h41 && c <= 8'h5A) ||
                        (c >= 8'h30 && c <= 8'h39) || c == 8'h20 || c == 8'h2B ||
                        c == 8'h2D || c == 8'h23 || c == 8'h2C || c == 8'h2E ||
                        c == 8'h28 || c == 8'h29;
      end
   endfunction

   function [7:0] out_pattern;
      input [7:0] code;
      input       direct;
      begin
         out_pattern = direct ? (8'h01 << code[2:0]) : code;
      end
   endfunction

   reg  [3:0]  sync1_q;
   reg  [3:0]  sync2_q;
   reg  [3:0]  prev_q;
   reg  [7:0]  act_q [0:NSLOT-1];
   reg  [1:0]  prof_q;
   reg  [13:0] stage_q;
   reg  [6:0]  pend_q;
   reg  [NUM_GROUPS-1:0] grp_valid_q;
   reg  [7:0]  grp_code_q   [0:NUM_GROUPS-1];
   reg         grp_direct_q [0:NUM_GROUPS-1];
   reg  [1:0]  grp_model_q  [0:NUM_GROUPS-1];
   reg  [12:0] grp_tol_q    [0:NUM_GROUPS-1];
   reg  [6:0]  grp_len_q    [0:NUM_GROUPS-1];
   reg  [NUM_COLORS-1:0] col_valid_q;
   reg  [2:0]  col_grp_q    [0:NUM_COLORS-1];
   reg  [15:0] col_c_q      [0:NUM_COLORS*3-1];
   reg  [31:0] gdef_q;
   reg  [2:0]  gsel_q;
   reg  [3:0]  csel_q;
   reg  [2:0]  cur_grp_q;
   reg         cur_valid_q;
   reg         name_err_q;
   reg  [31:0] tick_cnt_q;

   reg  [7:0]  req;
   reg  [4:0]  run;
   reg  [6:0]  done;
   reg         ev;
   integer     i;
   integer     e;
   integer     j;
   integer     s;

   wire [4:0]  free_grp = first_zero({{(16-NUM_GROUPS){1'b1}}, grp_valid_q});
   // Unused color slots read as taken so the search never lands on them.
   wire [31:0] col_pad   = ({32{1'b1}} << NUM_COLORS) | {{(32-NUM_COLORS){1'b0}}, col_valid_q};
   wire [31:0] grp_pad   = {{(32-NUM_GROUPS){1'b0}}, grp_valid_q};
   wire [4:0]  free_col  = first_zero(col_pad[15:0]);
   wire        wr_evt_ok = ({30'd0, stage_q[`STG_IN_LSB+1:`STG_IN_LSB]} < NUM_INPUTS);
   wire        wsel = wr_i;

   // Event detection and request gathering across inputs of the active profile.
   always @* begin
      req = 8'h00;
      ev  = 1'b0;
      for (i = 0; i < NUM_INPUTS; i = i + 1) begin
         for (e = 0; e < 4; e = e + 1) begin
            case (e[1:0])
               `EVT_HIGH: ev = sync2_q[i];
               `EVT_LOW:  ev = !sync2_q[i];
               `EVT_RISE: ev = sync2_q[i] && !prev_q[i];
               `EVT_FALL: ev = !sync2_q[i] && prev_q[i];
               default:   ev = 1'b0;
            endcase
            if (ev) begin
               req = req | act_q[prof_q * 16 + i * 4 + e];
            end
         end
      end
   end

   // One pending action runs per cycle, lowest index first.
   always @* begin
      run  = first_zero({9'h1FF, ~pend_q});
      done = 7'h00;
      if (run[4]) begin
         done[run[2:0]] = 1'b1;
      end
   end

   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
         prev_q  <= 4'h0;
      end else begin
         sync1_q <= trig_i;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tick_cnt_q    <= 32'h0000_0000;
         report_tick_o <= 1'b0;
      end else if (tick_cnt_q == REPORT_PERIOD - 1) begin
         tick_cnt_q    <= 32'h0000_0000;
         report_tick_o <= 1'b1;
      end else begin
         tick_cnt_q    <= tick_cnt_q + 32'h0000_0001;
         report_tick_o <= 1'b0;
      end
   end

   // Trigger action table, staging and control.
   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (s = 0; s < NSLOT; s = s + 1) begin
            act_q[s] <= 8'h00;
         end
         prof_q  <= 2'd0;
         stage_q <= 14'h0000;
         gdef_q  <= `GDEF_RESET;
         gsel_q  <= 3'd0;
         csel_q  <= 4'd0;
      end else if (wsel) begin
         case (addr_i)
            `REG_CTRL:  prof_q  <= wdata_i[`CTRL_PROF_LSB+1:`CTRL_PROF_LSB];
            `REG_STAGE: stage_q <= wdata_i[13:0];
            `REG_APPLY: begin
               if (wdata_i[0] && wr_evt_ok) begin
                  act_q[{stage_q[13:12], stage_q[11:10], stage_q[9:8]}] <= stage_q[7:0];
               end
            end
            `REG_GDEF:  gdef_q  <= wdata_i;
            `REG_GSEL:  gsel_q  <= wdata_i[2:0];
            `REG_CSEL:  csel_q  <= wdata_i[3:0];
            default:    gsel_q  <= gsel_q;
         endcase
      end
   end

   // Color table, group settings and action execution.
   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pend_q          <= 7'h00;
         grp_valid_q     <= {NUM_GROUPS{1'b0}};
         col_valid_q     <= {NUM_COLORS{1'b0}};
         for (j = 0; j < NUM_GROUPS; j = j + 1) begin
            grp_code_q[j]   <= 8'h00;
            grp_direct_q[j] <= 1'b0;
            grp_model_q[j]  <= `MODEL_CLASSIFY;
            grp_tol_q[j]    <= 13'h0000;
            grp_len_q[j]    <= 7'h00;
         end
         for (j = 0; j < NUM_COLORS; j = j + 1) begin
            col_grp_q[j] <= 3'd0;
         end
         for (j = 0; j < NUM_COLORS * 3; j = j + 1) begin
            col_c_q[j] <= 16'h0000;
         end
         cur_grp_q       <= 3'd0;
         cur_valid_q     <= 1'b0;
         name_err_q      <= 1'b0;
         key_lock_o      <= 1'b0;
         autogain_req_o  <= 1'b0;
         white_ref_req_o <= 1'b0;
         out_o           <= 8'h00;
      end else begin
         pend_q          <= (pend_q & ~done) | req[6:0];
         autogain_req_o  <= done[`ACT_AUTOGAIN];
         white_ref_req_o <= done[`ACT_WHITE_REF];
         if (req[`ACT_SWITCH_OUT]) begin
            out_o <= match_valid_i ? out_pattern(grp_code_q[match_grp_i], grp_direct_q[match_grp_i]) : 8'h00;
         end
         if (done[`ACT_KEY_LOCK]) begin
            key_lock_o <= 1'b1;
         end
         // Teach: new group when a color and a group slot are free, add/continuous into current group if one exists.
         if (done[`ACT_TEACH_NEW] || done[`ACT_TEACH_ADD] || done[`ACT_TEACH_CONT]) begin
            if (free_col[4] && (done[`ACT_TEACH_NEW] || !cur_valid_q)) begin
               if (free_grp[4]) begin
                  grp_valid_q[free_grp[2:0]]  <= 1'b1;
                  grp_code_q[free_grp[2:0]]   <= {5'd0, free_grp[2:0]} + 8'h01;
                  grp_direct_q[free_grp[2:0]] <= 1'b0;
                  grp_model_q[free_grp[2:0]]  <= gdef_q[`GC_MODEL_LSB+1:`GC_MODEL_LSB];
                  grp_tol_q[free_grp[2:0]]    <= gdef_q[`GC_TOL_LSB+`GC_TOL_W-1:`GC_TOL_LSB];
                  grp_len_q[free_grp[2:0]]    <= 7'h00;
                  col_valid_q[free_col[3:0]]  <= 1'b1;
                  col_grp_q[free_col[3:0]]    <= free_grp[2:0];
                  col_c_q[free_col[3:0]*3]    <= meas_c0_i;
                  col_c_q[free_col[3:0]*3+1]  <= meas_c1_i;
                  col_c_q[free_col[3:0]*3+2]  <= meas_c2_i;
                  cur_grp_q   <= free_grp[2:0];
                  cur_valid_q <= 1'b1;
               end
            end else if (free_col[4]) begin
               col_valid_q[free_col[3:0]] <= 1'b1;
               col_grp_q[free_col[3:0]]   <= cur_grp_q;
               col_c_q[free_col[3:0]*3]   <= meas_c0_i;
               col_c_q[free_col[3:0]*3+1] <= meas_c1_i;
               col_c_q[free_col[3:0]*3+2] <= meas_c2_i;
            end
         end
         if (wr_i) begin
            case (addr_i)
               `REG_CTRL: begin
                  // A trigger lock in the same cycle wins over a bus unlock.
                  key_lock_o <= wdata_i[`CTRL_LOCK_BIT] | done[`ACT_KEY_LOCK];
               end
               `REG_GCFG: begin
                  if (wdata_i[`GC_DIRECT_BIT] || wdata_i[7:0] != 8'h00) begin
                     grp_code_q[gsel_q]   <= wdata_i[7:0];
                     grp_direct_q[gsel_q] <= wdata_i[`GC_DIRECT_BIT];
                  end
                  grp_model_q[gsel_q] <= wdata_i[`GC_MODEL_LSB+1:`GC_MODEL_LSB];
                  if (wdata_i[`GC_TOL_LSB+`GC_TOL_W-1:`GC_TOL_LSB] <= `TOL_MAX) begin
                     grp_tol_q[gsel_q] <= wdata_i[`GC_TOL_LSB+`GC_TOL_W-1:`GC_TOL_LSB];
                  end
               end
               `REG_NAME: begin
                  if (wdata_i[8]) begin
                     grp_len_q[gsel_q] <= 7'h00;
                     name_err_q        <= 1'b0;
                  end else if (name_char_ok(wdata_i[7:0]) && grp_len_q[gsel_q] < `NAME_MAX_LEN) begin
                     grp_len_q[gsel_q] <= grp_len_q[gsel_q] + 7'h01;
                  end else begin
                     name_err_q <= 1'b1;
                  end
               end
               `REG_CVAL: begin
                  if (wdata_i[`CV_IDX_LSB+1:`CV_IDX_LSB] != 2'd3) begin
                     col_c_q[csel_q*3+wdata_i[`CV_IDX_LSB+1:`CV_IDX_LSB]] <= wdata_i[15:0];
                  end
               end
               `REG_CMD: begin
                  if (wdata_i[`CMD_DEL_COLOR]) begin
                     col_valid_q[csel_q] <= 1'b0;
                  end
                  if (wdata_i[`CMD_DEL_COLORS]) begin
                     col_valid_q <= {NUM_COLORS{1'b0}};
                  end
               end
               default: name_err_q <= name_err_q;
            endcase
         end
         // Group delete from bus or unlocked keypad.
         if ((wr_i && addr_i == `REG_CMD && wdata_i[`CMD_DEL_GROUP]) || (key_del_group_i && !key_lock_o)) begin
            grp_valid_q[gsel_q] <= 1'b0;
            for (j = 0; j < NUM_COLORS; j = j + 1) begin
               if (col_grp_q[j] == gsel_q) begin
                  col_valid_q[j] <= 1'b0;
               end
            end
            if (cur_grp_q == gsel_q) begin
               cur_valid_q <= 1'b0;
            end
         end
         // Table delete from bus, unlocked keypad or trigger.
         if ((wr_i && addr_i == `REG_CMD && wdata_i[`CMD_DEL_TABLE]) || (key_del_table_i && !key_lock_o) ||
             done[`ACT_DEL_TABLE]) begin
            grp_valid_q <= {NUM_GROUPS{1'b0}};
            col_valid_q <= {NUM_COLORS{1'b0}};
            cur_valid_q <= 1'b0;
         end
      end
   end

   // Read data stands in the cycle after the read strobe only.
   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_o <= 32'h0000_0000;
      end else if (rd_i) begin
         case (addr_i)
            `REG_CTRL:   rdata_o <= {27'd0, key_lock_o, 2'd0, prof_q};
            `REG_STAGE:  rdata_o <= {18'd0, stage_q};
            `REG_GSEL:   rdata_o <= {29'd0, gsel_q};
            `REG_GCFG:   rdata_o <= {5'd0, grp_len_q[gsel_q][2:0], grp_tol_q[gsel_q], grp_model_q[gsel_q],
                                     grp_direct_q[gsel_q], grp_code_q[gsel_q]};
            `REG_GDEF:   rdata_o <= gdef_q;
            `REG_CSEL:   rdata_o <= {28'd0, csel_q};
            `REG_STATUS: rdata_o <= {5'd0, pend_q, grp_len_q[gsel_q], name_err_q, cur_valid_q, cur_grp_q,
                                     grp_pad[7:0]};
            `REG_CINFO:  rdata_o <= {12'd0, col_valid_q[csel_q], col_grp_q[csel_q], col_c_q[csel_q*3]};
            default:     rdata_o <= 32'h0000_0000;
         endcase
      end else begin
         rdata_o <= 32'h0000_0000;
      end
   end

endmodule // trigger_input_action_dispatch

// ==== verification/trig_ctrl_model.sv ====
`timescale 1ns/100ps
module trig_ctrl_model (
   input  wire       ref_clk_i,
   input  wire       rst_b_i,
   input  wire [3:0] lvl_i,
   output reg  [3:0] trig_o
);
   reg [1:0] held_q;
   // A new level reaches the pins only once the previous one has stood four cycles.
   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         trig_o <= 4'h0;
         held_q <= 2'h0;
      end else if (lvl_i != trig_o && held_q == 2'h3) begin
         trig_o <= lvl_i;
         held_q <= 2'h0;
      end else if (held_q != 2'h3) begin
         held_q <= held_q + 2'h1;
      end
   end
endmodule // trig_ctrl_model

// ==== verification/trig_dispatch_chk.sv ====
`timescale 1ns/100ps
`include "trig_dispatch_defs.vh"
module trig_dispatch_chk #(
   parameter REPORT_PERIOD = 10
) (
   input wire        ref_clk_i,
   input wire        rst_b_i,
   input wire [7:0]  addr_i,
   input wire [31:0] wdata_i,
   input wire        wr_i,
   input wire        rd_i,
   input wire [31:0] rdata_o,
   input wire [7:0]  out_o,
   input wire        autogain_req_o,
   input wire        white_ref_req_o,
   input wire        key_lock_o,
   input wire        report_tick_o
);
   reg [31:0] gap_q;
   reg        seen_q;
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_b_i);
   // Cycles since the last report tick.
   always @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         gap_q  <= 32'h0000_0000;
         seen_q <= 1'b0;
      end else if (report_tick_o) begin
         gap_q  <= 32'h0000_0001;
         seen_q <= 1'b1;
      end else begin
         gap_q  <= gap_q + 32'h0000_0001;
      end
   end
   a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
      else $error("read data outside answer cycle");
   a_unmapped_read: assert property (rd_i && addr_i == 8'h30 |=> rdata_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_tick_period: assert property (report_tick_o && seen_q |-> gap_q == REPORT_PERIOD)
      else $error("report tick spacing wrong");
   a_tick_single: assert property (report_tick_o |=> !report_tick_o)
      else $error("report tick longer than one cycle");
   a_lock_set: assert property (wr_i && addr_i == `REG_CTRL && wdata_i[`CTRL_LOCK_BIT] |=> key_lock_o)
      else $error("key lock not set");
   a_table_empty: assert property ((wr_i && addr_i == `REG_CMD && wdata_i[`CMD_DEL_TABLE]) ##2
      (rd_i && addr_i == `REG_STATUS) |=> rdata_o[7:0] == 8'h00)
      else $error("groups left after table delete");
   a_reset_quiet: assert property ($rose(rst_b_i) |-> out_o == 8'h00 && !key_lock_o && !autogain_req_o
      && !white_ref_req_o)
      else $error("outputs active after reset");
   a_one_action: assert property (!(autogain_req_o && white_ref_req_o))
      else $error("two actions in one cycle");
endmodule // trig_dispatch_chk

bind trigger_input_action_dispatch trig_dispatch_chk #(.REPORT_PERIOD(REPORT_PERIOD)) u_chk (
   .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .out_o(out_o), .autogain_req_o(autogain_req_o),
   .white_ref_req_o(white_ref_req_o), .key_lock_o(key_lock_o), .report_tick_o(report_tick_o)
);

// ==== verification/testbench.sv ====
`timescale 1ns/100ps
`include "trig_dispatch_defs.vh"
module testbench;
   reg         clk;
   reg         rst_b;
   reg  [7:0]  addr;
   reg  [31:0] wdata;
   reg         wr;
   reg         rd;
   reg  [3:0]  lvl;
   reg         mv;
   reg         kg;
   reg         kt;
   wire [31:0] rdata;
   wire [3:0]  trig;
   wire [7:0]  outp;
   wire        ag;
   wire        wref;
   wire        lock;
   wire        tick;
   reg  [31:0] v;
   integer     fail_count;
   integer     n_checks;
   integer     na;
   integer     nw;
   integer     ta;
   integer     tw;
   integer     i;
   integer     m;

   trig_ctrl_model ctl (.ref_clk_i(clk), .rst_b_i(rst_b), .lvl_i(lvl), .trig_o(trig));
   trigger_input_action_dispatch #(.REPORT_PERIOD(10)) dut (
      .ref_clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .trig_i(trig), .match_valid_i(mv), .match_grp_i(3'h0), .meas_c0_i(16'h1234),
      .meas_c1_i(16'h0000), .meas_c2_i(16'h0000), .key_del_group_i(kg), .key_del_table_i(kt),
      .out_o(outp), .autogain_req_o(ag), .white_ref_req_o(wref), .key_lock_o(lock), .report_tick_o(tick));

   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask

   task wr_reg(input [7:0] a, input [31:0] d);
      begin
         @(posedge clk);
         addr  <= a;
         wdata <= d;
         wr    <= 1'b1;
         @(posedge clk);
         wr    <= 1'b0;
      end
   endtask

   task rd_reg(input [7:0] a);
      begin
         @(posedge clk);
         addr <= a;
         rd   <= 1'b1;
         @(posedge clk);
         rd   <= 1'b0;
         #1;
         v = rdata;
      end
   endtask

   task stage(input [1:0] prof, input [1:0] inp, input [1:0] evt, input [7:0] mask);
      begin
         wr_reg(`REG_STAGE, {18'h0_0000, prof, inp, evt, mask});
         wr_reg(`REG_APPLY, 32'h0000_0001);
      end
   endtask

   // Drives new trigger levels, then counts action pulses over n cycles.
   task trig_to(input [3:0] x, input integer n);
      begin
         @(posedge clk);
         lvl <= x;
         na = 0;
         nw = 0;
         ta = -1;
         tw = -1;
         for (i = 0; i < n; i = i + 1) begin
            @(posedge clk);
            #1;
            if (ag === 1'b1) begin
               na = na + 1;
               ta = i;
            end
            if (wref === 1'b1) begin
               nw = nw + 1;
               tw = i;
            end
         end
      end
   endtask

   task key(input g, input t);
      begin
         @(posedge clk);
         kg <= g;
         kt <= t;
         @(posedge clk);
         kg <= 1'b0;
         kt <= 1'b0;
      end
   endtask

   task s_reset;
      begin
         rd_reg(`REG_STATUS);
         chk(v & 32'h0000_00FF, 32'h0000_0000);
         rd_reg(8'h30);
         chk(v, 32'h0000_0000);
      end
   endtask

   task s_apply;
      begin
         wr_reg(`REG_STAGE, {20'h0_0000, 2'h0, `EVT_RISE, 8'h10});
         trig_to(4'h1, 8);
         chk(na, 0);
         trig_to(4'h0, 6);
         wr_reg(`REG_APPLY, 32'h0000_0001);
         trig_to(4'h1, 8);
         chk(na, 1);
         chk(ta, 4);
      end
   endtask

   task s_multi;
      begin
         stage(2'h0, 2'h1, `EVT_FALL, 8'h30);
         trig_to(4'h3, 6);
         trig_to(4'h1, 10);
         chk(na, 1);
         chk(nw, 1);
         chk(tw, ta + 1);
      end
   endtask

   task s_profile;
      begin
         stage(2'h1, 2'h2, `EVT_RISE, 8'h20);
         trig_to(4'h5, 8);
         chk(nw, 0);
         trig_to(4'h1, 6);
         wr_reg(`REG_CTRL, 32'h0000_0001);
         trig_to(4'h5, 8);
         chk(nw, 1);
         trig_to(4'h1, 6);
         wr_reg(`REG_CTRL, 32'h0000_0000);
      end
   endtask

   task s_teach_switch;
      begin
         stage(2'h0, 2'h2, `EVT_RISE, 8'h02);
         trig_to(4'h5, 8);
         trig_to(4'h1, 6);
         rd_reg(`REG_STATUS);
         chk(v & 32'h0000_00FF, 32'h0000_0001);
         rd_reg(`REG_CINFO);
         chk(v, 32'h0008_1234);
         for (m = 0; m < 4; m = m + 1) begin
            wr_reg(`REG_GCFG, 32'h0000_005A | (m << 9));
            rd_reg(`REG_GCFG);
            chk(v & 32'h0000_07FF, 32'h0000_005A | (m << 9));
         end
         stage(2'h0, 2'h3, `EVT_HIGH, 8'h80);
         trig_to(4'h9, 6);
         chk(outp, 8'h5A);
         wr_reg(`REG_GCFG, 32'h0000_0103);
         trig_to(4'h9, 4);
         chk(outp, 8'h08);
         @(posedge clk);
         mv <= 1'b0;
         trig_to(4'h9, 4);
         chk(outp, 8'h00);
         @(posedge clk);
         mv <= 1'b1;
         wr_reg(`REG_GCFG, 32'h0000_0033);
         trig_to(4'h9, 4);
         chk(outp, 8'h33);
         trig_to(4'h1, 6);
         wr_reg(`REG_GCFG, 32'h0000_000F);
         trig_to(4'h1, 4);
         chk(outp, 8'h33);
      end
   endtask

   task s_delete;
      begin
         key(1'b1, 1'b0);
         rd_reg(`REG_STATUS);
         chk(v & 32'h0000_00FF, 32'h0000_0000);
         rd_reg(`REG_CINFO);
         chk(v & 32'h0008_0000, 32'h0000_0000);
         trig_to(4'h5, 8);
         trig_to(4'h1, 6);
         wr_reg(`REG_CMD, 32'h0000_0002);
         rd_reg(`REG_CINFO);
         chk(v & 32'h0008_0000, 32'h0000_0000);
         rd_reg(`REG_STATUS);
         chk(v & 32'h0000_00FF, 32'h0000_0001);
         wr_reg(`REG_CTRL, 32'h0000_0010);
         key(1'b0, 1'b1);
         rd_reg(`REG_STATUS);
         chk(v & 32'h0000_00FF, 32'h0000_0001);
         chk(lock, 1'b1);
         wr_reg(`REG_CTRL, 32'h0000_0000);
         wr_reg(`REG_CMD, 32'h0000_0004);
         rd_reg(`REG_STATUS);
         chk(v & 32'h0000_00FF, 32'h0000_0000);
      end
   endtask

   // Name length and error flag, then tolerance limit and refused code zero.
   task s_name;
      begin
         wr_reg(`REG_NAME, 32'h0000_0100);
         wr_reg(`REG_NAME, 32'h0000_0041);
         wr_reg(`REG_NAME, 32'h0000_0021);
         rd_reg(`REG_STATUS);
         chk(v & 32'h000F_F000, 32'h0000_3000);
         wr_reg(`REG_GCFG, 32'h009C_4000);
         wr_reg(`REG_GCFG, 32'h009C_4800);
         rd_reg(`REG_GCFG);
         chk(v & 32'h00FF_FFFF, 32'h009C_4001);
      end
   endtask

   // Any 20 consecutive cycles hold exactly two ticks at a period of 10.
   task s_tick;
      begin
         na = 0;
         for (i = 0; i < 20; i = i + 1) begin
            @(posedge clk);
            #1;
            if (tick === 1'b1) begin
               na = na + 1;
            end
         end
         chk(na, 2);
      end
   endtask

   task final_report;
      begin
         $display("checks %0d mismatches %0d", n_checks, fail_count);
         if (fail_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      rst_b = 1'b0;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      wr = 1'b0;
      rd = 1'b0;
      lvl = 4'h0;
      mv = 1'b1;
      kg = 1'b0;
      kt = 1'b0;
      fail_count = 0;
      n_checks = 0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      s_reset;
      s_apply;
      s_multi;
      s_profile;
      s_teach_switch;
      s_delete;
      s_name;
      s_tick;
      final_report;
   end
endmodule // testbench
